// ---- src/usr_consts.vh ----
// constants for the serial receiver status block
`ifndef USR_CONSTS_VH
`define USR_CONSTS_VH

// register offsets (3-bit register address)
`define USR_ADDR_CMD      3'h0
`define USR_ADDR_STATUS   3'h1
`define USR_ADDR_MODE     3'h2
`define USR_ADDR_SYNCCHR  3'h3
`define USR_ADDR_RXDATA   3'h4

// command register fields
`define USR_CMD_RXEN      2
`define USR_CMD_ERRCLR    4
`define USR_CMD_SWRST     6
`define USR_CMD_HUNT      7

// status register fields
`define USR_ST_RXRDY      1
`define USR_ST_HUNTING    2
`define USR_ST_FRAMERR    5
`define USR_ST_SYNBRK     6
`define USR_ST_DSR        7

// mode register fields
`define USR_MODE_SYNC     0
`define USR_MODE_EXTSYNC  1
`define USR_MODE_LEN_LO   2
`define USR_MODE_LEN_HI   3

// reset values
`define USR_CMD_RST       8'h00
`define USR_MODE_RST      8'h0c
`define USR_SYNCCHR_RST   8'h16

// async timing in receive clock rising edges
`define USR_OVERSAMPLE    5'h10
`define USR_HALFBIT       5'h08

`endif

// ---- src/usr_status.v ----
// serial receiver with sync/break detect, framing error and modem status
// Function
// R1 - sync mode: sync found sets bit, read clears
// R2 - async: line low over two characters sets break
// R3 - async: break clears on line high or reset
// R4 - status dsr bit is inverse of modem input
// R5 - modem input sampled on system clock first
// R6 - host writes zero three times before software reset
// R7 - host sets error clear with enable plus hunt
// R8 - characters after framing error flagged unreliable
// R9 - external sync input sampled while receive clock high
// R10 - external sync high re-sets flag after read clear
// R11 - status bit mirrors pin, frozen during readout
// R12 - zero at first stop centre sets framing error
`include "usr_consts.vh"
`default_nettype none

module usr_status (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire [2:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       rxd_i,
  input  wire       dsr_n_i,
  input  wire       receive_clock_input_i,
  input  wire       external_sync_detect_input_i,
  output wire       sync_break_detect_pin_o
);

  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_START = 4'b0010;
  localparam [3:0] ST_DATA  = 4'b0100;
  localparam [3:0] ST_STOP  = 4'b1000;

  // data bits per character, 5 to 8
  function [3:0] char_bits;
    input [1:0] len;
    begin
      char_bits = 4'd5 + {2'b00, len};
    end
  endfunction

  // pin synchronisers: stage one is read only by stage two
  reg [1:0] rxd_q;
  reg [1:0] dsr_q;
  reg [1:0] rxc_q;
  reg [1:0] ext_q;
  reg       rxc_old_q;

  always @(posedge clk_i) begin
    if (srst_i) begin
      rxd_q     <= 2'b11;
      dsr_q     <= 2'b11;
      rxc_q     <= 2'b00;
      ext_q     <= 2'b00;
      rxc_old_q <= 1'b0;
    end else begin
      rxd_q     <= {rxd_q[0], rxd_i};
      dsr_q     <= {dsr_q[0], dsr_n_i}; // see R5
      rxc_q     <= {rxc_q[0], receive_clock_input_i};
      ext_q     <= {ext_q[0], external_sync_detect_input_i};
      rxc_old_q <= rxc_q[1];
    end
  end

  wire rxd_s   = rxd_q[1];
  wire rxc_s   = rxc_q[1];
  wire rxc_edg = rxc_s & ~rxc_old_q;

  // software registers
  reg [7:0] cmd_q;
  reg [7:0] mode_q;
  reg [7:0] sync_chr_q;

  wire wr_cmd   = wr_i && (addr_i == `USR_ADDR_CMD);
  wire sw_rst   = wr_cmd && wdata_i[`USR_CMD_SWRST];
  wire err_clr  = wr_cmd && wdata_i[`USR_CMD_ERRCLR];
  wire hunt_go  = wr_cmd && wdata_i[`USR_CMD_HUNT];
  wire rd_stat  = rd_i && (addr_i == `USR_ADDR_STATUS);
  wire rd_data  = rd_i && (addr_i == `USR_ADDR_RXDATA);
  wire blk_rst  = srst_i | sw_rst;

  wire       sync_md = mode_q[`USR_MODE_SYNC];
  wire       ext_md  = mode_q[`USR_MODE_EXTSYNC];
  wire [3:0] nbits   = char_bits(mode_q[`USR_MODE_LEN_HI:`USR_MODE_LEN_LO]);
  wire       rx_en   = cmd_q[`USR_CMD_RXEN];

  // command strobe bits do not stay set; a reset command leaves mode intact
  always @(posedge clk_i) begin
    if (srst_i) begin
      cmd_q      <= `USR_CMD_RST;
      mode_q     <= `USR_MODE_RST;
      sync_chr_q <= `USR_SYNCCHR_RST;
    end else begin
      if (sw_rst) begin
        cmd_q <= `USR_CMD_RST;
      end else if (wr_cmd) begin
        cmd_q <= wdata_i & 8'h2f;
      end
      if (wr_i && (addr_i == `USR_ADDR_MODE)) begin
        mode_q <= wdata_i;
      end
      if (wr_i && (addr_i == `USR_ADDR_SYNCCHR)) begin
        sync_chr_q <= wdata_i;
      end
    end
  end

  // async receiver and break timing
  reg [3:0] state_q;
  reg [4:0] tick_q;
  reg [3:0] bit_q;
  reg [7:0] shift_q;
  reg [7:0] rx_data_q;
  reg       rx_rdy_q;
  reg       fe_q;
  reg [8:0] low_q;
  reg       brk_q;
  reg       hunt_q;
  reg       syn_q;

  // break threshold: two whole frames of zero samples
  wire [8:0] frame_len = {5'h00, nbits} + 9'd2;
  wire [8:0] brk_lim   = {frame_len[3:0], 5'h00};
  wire       async_on  = rx_en && !sync_md;

  always @(posedge clk_i) begin
    if (blk_rst) begin
      state_q   <= ST_IDLE;
      tick_q    <= 5'h00;
      bit_q     <= 4'h0;
      shift_q   <= 8'h00;
      rx_data_q <= 8'h00;
      rx_rdy_q  <= 1'b0;
      fe_q      <= 1'b0;
      low_q     <= 9'h000;
      brk_q     <= 1'b0;
    end else begin
      if (rd_data) begin
        rx_rdy_q <= 1'b0;
      end
      if (err_clr) begin
        fe_q <= 1'b0; // see R12
      end
      // break: long low run sets, any high level clears
      if (!async_on || rxd_s) begin
        low_q <= 9'h000;
        brk_q <= 1'b0; // see R3
      end else if (rxc_edg) begin
        if (low_q != 9'h1ff) begin
          low_q <= low_q + 9'h001;
        end
        if (low_q > brk_lim) begin
          brk_q <= 1'b1; // see R2
        end
      end
      if (!async_on) begin
        state_q <= ST_IDLE;
      end else if (rxc_edg) begin
        case (state_q)
          ST_IDLE: begin
            tick_q <= 5'h00;
            if (!rxd_s) begin
              state_q <= ST_START;
            end
          end
          ST_START: begin
            tick_q <= tick_q + 5'h01;
            if (tick_q == `USR_HALFBIT - 5'h01) begin
              tick_q  <= 5'h00;
              bit_q   <= 4'h0;
              state_q <= rxd_s ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            tick_q <= tick_q + 5'h01;
            if (tick_q == `USR_OVERSAMPLE - 5'h01) begin
              tick_q  <= 5'h00;
              shift_q <= {rxd_s, shift_q[7:1]};
              bit_q   <= bit_q + 4'h1;
              if (bit_q == nbits - 4'h1) begin
                state_q <= ST_STOP;
              end
            end
          end
          ST_STOP: begin
            tick_q <= tick_q + 5'h01;
            if (tick_q == `USR_OVERSAMPLE - 5'h01) begin
              // only the first stop bit centre is looked at
              state_q   <= ST_IDLE;
              rx_data_q <= shift_q >> (4'h8 - nbits);
              if (!rxd_s) begin
                fe_q <= 1'b1; // see R12
              end else if (!fe_q) begin
                rx_rdy_q <= 1'b1; // see R8
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // sync mode: hunt for the sync character or take the external strobe
  reg  [7:0] sync_sh_q;
  wire [7:0] sync_next = {rxd_s, sync_sh_q[7:1]};
  wire [7:0] sync_msk  = 8'hff >> (4'h8 - nbits);
  wire [7:0] sync_al   = sync_next >> (4'h8 - nbits);
  wire       int_hit   = sync_md && !ext_md && hunt_q && rx_en && rxc_edg &&
                         ((sync_al & sync_msk) == (sync_chr_q & sync_msk));
  // external strobe looked at for as long as the receive clock is high
  // not gated by receive enable: the strobe is honoured whenever the clock is high
  wire       ext_hit   = sync_md && ext_md && rxc_s && ext_q[1]; // see R9

  always @(posedge clk_i) begin
    if (blk_rst) begin
      sync_sh_q <= 8'h00;
      hunt_q    <= 1'b0;
      syn_q     <= 1'b0;
    end else begin
      if (rxc_edg) begin
        sync_sh_q <= sync_next;
      end
      if (int_hit) begin
        hunt_q <= 1'b0;
      end else if (hunt_go) begin
        hunt_q <= 1'b1;
      end
      // a hit in the read cycle wins over the read clear
      if (int_hit || ext_hit) begin
        syn_q <= 1'b1; // see R1, R10
      end else if (rd_stat || !sync_md) begin
        syn_q <= 1'b0; // see R1
      end
    end
  end

  wire sb_flag = sync_md ? syn_q : brk_q;

  // pin driven from the flag flops; readout snapshots the same flag
  assign sync_break_detect_pin_o = sb_flag; // see R11

  // read data: registered snapshot, present only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == `USR_ADDR_CMD) begin
        rdata_o <= cmd_q;
      end else if (addr_i == `USR_ADDR_STATUS) begin
        rdata_o <= {~dsr_q[1], sb_flag, fe_q, 2'b00, hunt_q, rx_rdy_q, 1'b0}; // see R4, R11
      end else if (addr_i == `USR_ADDR_MODE) begin
        rdata_o <= mode_q;
      end else if (addr_i == `USR_ADDR_SYNCCHR) begin
        rdata_o <= sync_chr_q;
      end else if (addr_i == `USR_ADDR_RXDATA) begin
        rdata_o <= rx_data_q;
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // usr_status

`default_nettype wire

// ---- test/usr_status_asserts.sv ----
// port checker for the serial status block
`default_nettype none
module usr_status_chk (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rxd_i,
  input wire logic       dsr_n_i,
  input wire logic       receive_clock_input_i,
  input wire logic       external_sync_detect_input_i,
  input wire logic       sync_break_detect_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] m_q;
  wire logic  st  = rd_i && addr_i == 3'h1;
  wire logic  ex  = m_q[1:0] == 2'h3;
  wire logic  pin = sync_break_detect_pin_o;
  wire logic  hit = ex && external_sync_detect_input_i && receive_clock_input_i;
  // mode shadow; software reset leaves the mode alone, so only writes move it
  always_ff @(posedge clk_i) begin
    if (srst_i) m_q <= 8'h0c;
    else if (wr_i && addr_i == 3'h2) m_q <= wdata_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_dsr_lo; !dsr_n_i [*5] ##0 st |=> rdata_o[7]; endproperty
  a_dsr_lo: assert property (p_dsr_lo) else $error("ready bit low");
  property p_dsr_hi; dsr_n_i [*5] ##0 st |=> !rdata_o[7]; endproperty
  a_dsr_hi: assert property (p_dsr_hi) else $error("ready bit high");
  property p_mirror; st |=> rdata_o[6] == $past(pin); endproperty
  a_mirror: assert property (p_mirror) else $error("bit6 not pin");
  property p_ext_set; hit [*6] |-> pin; endproperty
  a_ext_set: assert property (p_ext_set) else $error("sync not seen");
  property p_resync; st ##1 hit [*5] |-> pin; endproperty
  a_resync: assert property (p_resync) else $error("sync not re-set");
  property p_ext_clr; (ex && !external_sync_detect_input_i) [*6] ##0 st |=> !pin; endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("read kept sync");
  property p_brk_clr; (!m_q[0] && rxd_i) [*6] |-> !pin; endproperty
  a_brk_clr: assert property (p_brk_clr) else $error("break stuck");
  c_sync: cover property (st && pin && ex);
  c_brk: cover property (st && pin && !m_q[0]);
  c_dsr: cover property (st ##1 rdata_o[7]);
endmodule // usr_status_chk
bind usr_status usr_status_chk chk (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .rxd_i, .dsr_n_i, .receive_clock_input_i,
  .external_sync_detect_input_i, .sync_break_detect_pin_o);
`default_nettype wire

// ---- test/usr_station.sv ----
// remote station: receive line, receive clock, modem and sync inputs
`default_nettype none
module usr_station (
  output var logic rxc_o,
  output var logic rxd_o,
  output var logic ext_o,
  output var logic dsr_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run = 1'b0;
  // 125 ns receive clock, parked low between frames
  initial begin
    rxc_o = 1'b0;
    rxd_o = 1'b1;
    ext_o = 1'b0;
    dsr_n_o = 1'b1;
    forever #62.5 rxc_o = run & ~rxc_o;
  end
  // line moves 20 ns after a rising edge so it never races the sampling edge
  task line(input logic v, input int n);
    rxd_o = v;
    run = 1'b1;
    repeat (n) @(posedge rxc_o);
    #20;
  endtask
  task chr(input logic [7:0] d);
    line(1'b0, 16);
    for (int i = 0; i < 8; i++) line(d[i], 16);
    line(1'b1, 32);
    run = 1'b0;
  endtask
  // synchronous bits, one receive clock each, lsb first, then clock parked
  task sync(input logic [7:0] d);
    for (int i = 0; i < 8; i++) line(d[i], 1);
    run = 1'b0;
  endtask
endmodule // usr_station
`default_nettype wire

// ---- test/usr_status_tb.sv ----
// testbench for the serial status block
`default_nettype none
module usr_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
  logic [2:0]  addr_i = 3'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic [15:0] exp_q[$];
  logic [7:0]  sc;
  wire logic [7:0] rdata_o;
  wire logic   rxd, receive_clock_input, ext, dsr_n, pin;
  int          num_errors = 0, n_tests = 0;
  initial forever #2.5 clk_i = ~clk_i;
  usr_status dut (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .rxd_i(rxd), .dsr_n_i(dsr_n), .receive_clock_input_i(receive_clock_input),
    .external_sync_detect_input_i(ext), .sync_break_detect_pin_o(pin));
  usr_station station (.rxc_o(receive_clock_input), .rxd_o(rxd), .ext_o(ext), .dsr_n_o(dsr_n));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read: mask and expected value are queued for the monitor
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] x);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back({m, x});
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    n_tests++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED rdata exp %h got %h", x, s);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe: look mid-cycle
  always @(posedge clk_i) rd_d <= rd_i;
  always @(negedge clk_i) begin : mon
    logic [15:0] e;
    if (rd_d) begin
      e = exp_q.pop_front();
      chk(rdata_o & e[15:8], e[7:0]);
    end
  end
  // a hang counts as a mismatch
  initial begin
    #400us;
    num_errors++;
    results();
  end
  initial begin
    void'($urandom(90));
    tick(2);
    srst_i <= 1'b0;
    rd(3'h1, 8'hff, 8'h00);
    rd(3'h5 + 3'($urandom % 3), 8'hff, 8'h00);
    station.dsr_n_o <= 1'b0;
    tick(5 + $urandom % 8);
    rd(3'h1, 8'h80, 8'h80);
    station.dsr_n_o <= 1'b1;
    tick(6);
    rd(3'h1, 8'h80, 8'h00);
    // external sync mode, input held high across status reads
    wr(3'h2, 8'h0f);
    wr(3'h0, 8'h94);
    station.ext_o <= 1'b1;
    station.run = 1'b1;
    tick(80);
    rd(3'h1, 8'h44, 8'h44);
    tick(80);
    rd(3'h1, 8'h40, 8'h40);
    // one more clock-high phase sets the flag again before the input drops
    tick(30);
    station.ext_o <= 1'b0;
    tick(10);
    rd(3'h1, 8'h40, 8'h40);
    rd(3'h1, 8'h40, 8'h00);
    station.run = 1'b0;
    for (int i = 0; i < 3; i++) wr(3'h0, 8'h00);
    wr(3'h0, 8'h40);
    rd(3'h1, 8'h44, 8'h00);
    wr(3'h2, 8'h0c);
    wr(3'h0, 8'h14);
    // break: line low past two characters of zeros
    station.line(1'b0, 340);
    rd(3'h1, 8'h60, 8'h60);
    station.line(1'b1, 8);
    station.run = 1'b0;
    rd(3'h1, 8'h62, 8'h20);
    // the break left the receiver mid-frame: drop and re-raise enable, error kept
    wr(3'h0, 8'h00);
    wr(3'h0, 8'h04);
    station.chr(8'h3c);
    rd(3'h1, 8'h22, 8'h20);
    wr(3'h0, 8'h14);
    rd(3'h1, 8'h20, 8'h00);
    station.chr(8'ha5);
    rd(3'h1, 8'h22, 8'h02);
    rd(3'h4, 8'hff, 8'ha5);
    // internal sync hunt: bit 0 low so no partial window against the idle ones matches
    sc = 8'($urandom) & 8'hfe;
    wr(3'h3, sc);
    wr(3'h2, 8'h0d);
    wr(3'h0, 8'h94);
    rd(3'h1, 8'h44, 8'h04);
    station.sync(sc);
    tick(4);
    rd(3'h1, 8'h44, 8'h40);
    rd(3'h1, 8'h40, 8'h00);
    results();
  end
endmodule // usr_status_tb
`default_nettype wire
